// ### rtl/cea_alu.sv
/*
 * Combinational arithmetic for the extended compare and add group.
 * Assumes operands and prior flags are held stable by the sequencer.
 */
`timescale 1ns/1ps
module cea_alu
  import cea_pkg::*;
(
  cea_alu_if.alu bus
);

  // ****************************************************************
  // Widened operands and sums
  // ****************************************************************
  wire [33:0] ud = {2'b00, bus.d};
  wire [33:0] us = {2'b00, bus.s};
  wire [33:0] sd = {{2{bus.d[31]}}, bus.d};
  wire [33:0] ss = {{2{bus.s[31]}}, bus.s};
  wire [33:0] cin = {33'h0, bus.c_in};
  wire [33:0] u_add = ud + us + cin;
  wire [33:0] u_sub = ud - us - cin;
  wire [33:0] u_sub0 = ud - us;
  wire [33:0] s_add = sd + ss + cin;
  wire [33:0] s_sub = sd - ss - cin;
  wire [33:0] s_add0 = sd + ss;
  wire [33:0] s_sub0 = sd - ss;
  wire [31:0] dec = bus.d - 32'h0000_0001;
  wire d_ge_s = ~u_sub0[33];

  // Per opcode result, flags and write decision
  always_comb begin
    bus.result = bus.d;
    bus.z_out = bus.z_in;
    bus.c_out = bus.c_in;
    bus.write = 1'b0;
    bus.jump = 1'b0;
    bus.legal = 1'b1;
    unique case (bus.opcode)
      OP_SIGNED_COMPARE: begin
        bus.result = s_sub0[31:0];
        bus.z_out = (bus.d == bus.s);
        bus.c_out = s_sub0[33];
      end
      OP_SIGNED_COMPARE_CHAINED: begin
        bus.result = s_sub[31:0];
        bus.z_out = bus.z_in & (s_sub[31:0] == 32'h0);
        bus.c_out = s_sub[33];
      end
      OP_ADD_WITH_CARRY_CHAINED: begin
        bus.result = u_add[31:0];
        bus.z_out = bus.z_in & (u_add[31:0] == 32'h0);
        bus.c_out = u_add[32];
        bus.write = bus.result_en;
      end
      OP_SUBTRACT_WITH_BORROW_CHAINED: begin
        bus.result = u_sub[31:0];
        bus.z_out = bus.z_in & (u_sub[31:0] == 32'h0);
        bus.c_out = u_sub[33];
        bus.write = bus.result_en;
      end
      OP_SIGNED_ADD: begin
        bus.result = s_add0[31:0];
        bus.z_out = (s_add0[31:0] == 32'h0);
        bus.c_out = s_add0[32] ^ s_add0[31];
        bus.write = bus.result_en;
      end
      OP_SIGNED_SUBTRACT: begin
        bus.result = s_sub0[31:0];
        bus.z_out = (s_sub0[31:0] == 32'h0);
        bus.c_out = s_sub0[32] ^ s_sub0[31];
        bus.write = bus.result_en;
      end
      OP_SIGNED_ADD_CHAINED: begin
        bus.result = s_add[31:0];
        bus.z_out = bus.z_in & (s_add[31:0] == 32'h0);
        bus.c_out = s_add[32] ^ s_add[31];
        bus.write = bus.result_en;
      end
      OP_SIGNED_SUBTRACT_CHAINED: begin
        bus.result = s_sub[31:0];
        bus.z_out = bus.z_in & (s_sub[31:0] == 32'h0);
        bus.c_out = s_sub[32] ^ s_sub[31];
        bus.write = bus.result_en;
      end
      OP_CONDITIONAL_SUBTRACT: begin
        bus.result = d_ge_s ? u_sub0[31:0] : bus.d;
        bus.z_out = (bus.d == bus.s);
        bus.c_out = d_ge_s;
        bus.write = bus.result_en & d_ge_s;
      end
      OP_DECREMENT_BRANCH_NONZERO: begin
        bus.result = dec;
        bus.z_out = (dec == 32'h0);
        bus.c_out = (bus.d == 32'h0);
        bus.write = bus.result_en;
        bus.jump = (dec != 32'h0);
      end
      default: begin
        bus.legal = 1'b0;
      end
    endcase
  end

endmodule : cea_alu

// ### rtl/cea_alu_if.sv
/*
 * Bundle between the sequencer and the combinational arithmetic unit.
 * Assumes both ends sit in the same pclk domain.
 */
`timescale 1ns/1ps
interface cea_alu_if;
  logic [5:0] opcode;
  logic result_en;
  logic [31:0] d;
  logic [31:0] s;
  logic z_in;
  logic c_in;
  logic [31:0] result;
  logic z_out;
  logic c_out;
  logic write;
  logic jump;
  logic legal;

  modport core (
    output opcode, result_en, d, s, z_in, c_in,
    input result, z_out, c_out, write, jump, legal
  );
  modport alu (
    input opcode, result_en, d, s, z_in, c_in,
    output result, z_out, c_out, write, jump, legal
  );
endinterface : cea_alu_if

// ### rtl/cea_core.sv
/*
 * Extended arithmetic and compare datapath with APB register access.
 * Software loads register memory, writes an instruction word, and
 * reads back flags, result and program counter.
 * Assumes an APB master on pclk; no other party touches the memory.
 */
// Behaviour
// - Signed compare sets Z on equal, C on signed borrow, no write, 4 clocks.
// - Chained signed compare ANDs prior Z, C on signed borrow, no write.
// - Chained add writes D+S+C, C on carry-out, Z chained.
// - Chained subtract writes D-(S+C), C on borrow, Z chained.
// - Same opcode with result bit clear compares only, flags identical.
// - Signed add/subtract write result, Z on zero, C on overflow.
// - Chained signed add writes D+S+C, C overflow, Z chained.
// - Chained signed subtract writes D-(S+C), C overflow, Z chained.
// - Conditional subtract only if D>=S; C when done, Z when equal.
// - Decrement, write back, jump if nonzero; not taken takes 8 clocks.
// - Word holds opcode, effect with immediate bit, condition, dest, src.
`timescale 1ns/1ps
module cea_core
  import cea_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cea_state_t state_reg, state_next;
  logic [31:0] instr_reg;
  logic [31:0] d_reg;
  logic [31:0] result_reg;
  logic [8:0] pc_reg;
  logic [8:0] mem_addr_reg;
  logic [3:0] hold_reg;
  logic z_reg, c_reg;
  logic z_new_reg, c_new_reg;
  logic wr_pend_reg, jump_pend_reg, exec_pend_reg;
  logic wrote_reg, jumped_reg, illegal_reg;
  logic [31:0] prdata_reg;
  logic [31:0] mem_rdata;
  logic [31:0] rd_mux;

  cea_alu_if alu_bus ();

  // ****************************************************************
  // Instruction fields
  // ****************************************************************
  // Field slicing of the held instruction word
  wire [5:0] f_opcode = instr_reg[OPC_LSB +: 6];
  wire [3:0] f_effect = instr_reg[EFF_LSB +: 4];
  wire [3:0] f_cond = instr_reg[COND_LSB +: 4];
  wire [8:0] f_dst = instr_reg[DST_LSB +: 9];
  wire [8:0] f_src = instr_reg[SRC_LSB +: 9];
  wire f_imm = f_effect[IMM_BIT];
  wire f_res = f_effect[RESULT_BIT];
  wire f_exec = (f_cond == COND_ALWAYS);

  // Compare opcodes never write their destination
  wire no_write_op = (f_opcode == OP_SIGNED_COMPARE) ||
                     (f_opcode == OP_SIGNED_COMPARE_CHAINED);

  // Source operand: immediate or register memory
  wire [31:0] s_operand = f_imm ? {23'h0, f_src} : mem_rdata;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire busy = (state_reg != ST_IDLE);
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_instr = (paddr == ADDR_INSTR);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_flags = (paddr == ADDR_FLAGS);
  wire hit_pc = (paddr == ADDR_PC);
  wire hit_maddr = (paddr == ADDR_MEM_ADDR);
  wire hit_mdata = (paddr == ADDR_MEM_DATA);
  wire hit_result = (paddr == ADDR_RESULT);
  wire mapped = hit_instr | hit_status | hit_flags | hit_pc |
                hit_maddr | hit_mdata | hit_result;
  wire ro_hit = hit_status | hit_result;
  // Writes that would disturb a running instruction are refused
  wire busy_clash = busy & (hit_instr | hit_flags | hit_pc | hit_mdata);
  wire wr_err = pwrite & (ro_hit | busy_clash);
  wire bad = ~mapped | wr_err;
  wire wr_ok = access & pwrite & ~bad;
  wire start = wr_ok & hit_instr;

  assign pready = 1'b1;
  assign pslverr = access & bad;
  assign prdata = prdata_reg;

  // Read data multiplexer
  assign rd_mux =
    hit_instr ? instr_reg :
    hit_status ? {28'h0, illegal_reg, jumped_reg, wrote_reg, busy} :
    hit_flags ? {30'h0, c_reg, z_reg} :
    hit_pc ? {23'h0, pc_reg} :
    hit_maddr ? {23'h0, mem_addr_reg} :
    hit_mdata ? mem_rdata :
    hit_result ? result_reg : RST_WORD;

  // Read data captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RST_WORD;
    end else if (setup & ~pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // ****************************************************************
  // Register memory and arithmetic unit
  // ****************************************************************
  // Memory read address follows the sequencer, else the APB pointer;
  // a pointer write fetches its new word at once for the next read
  wire [8:0] mem_raddr =
    (state_reg == ST_READ_D) ? f_dst :
    (state_reg == ST_READ_S) ? f_src :
    (wr_ok & hit_maddr) ? pwdata[8:0] : mem_addr_reg;
  wire commit = (state_reg == ST_COMMIT);
  wire mem_we = (commit & wr_pend_reg) | (wr_ok & hit_mdata);
  wire [31:0] mem_wdata = commit ? result_reg : pwdata;
  wire [8:0] mem_waddr = commit ? f_dst : mem_addr_reg;

  cea_regmem u_regmem (
    .pclk(pclk),
    .raddr(mem_raddr),
    .rdata(mem_rdata),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata)
  );

  assign alu_bus.opcode = f_opcode;
  assign alu_bus.result_en = f_res & ~no_write_op;
  assign alu_bus.d = d_reg;
  assign alu_bus.s = s_operand;
  assign alu_bus.z_in = z_reg;
  assign alu_bus.c_in = c_reg;

  cea_alu u_alu (
    .bus(alu_bus)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next state: read D, read S, execute, commit, optional hold
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_READ_D;
        end
      end
      ST_READ_D: begin
        state_next = ST_READ_S;
      end
      ST_READ_S: begin
        state_next = ST_EXEC;
      end
      ST_EXEC: begin
        state_next = ST_COMMIT;
      end
      ST_COMMIT: begin
        if (exec_pend_reg & ~jump_pend_reg &&
            f_opcode == OP_DECREMENT_BRANCH_NONZERO) begin
          state_next = ST_HOLD;
        end else begin
          state_next = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (hold_reg == 4'h1) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Extra wait count for an untaken decrement branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 4'h0;
    end else if (commit) begin
      hold_reg <= EXTRA_WAIT;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end

  // Instruction word and destination operand capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= RST_WORD;
      d_reg <= RST_WORD;
    end else begin
      if (start) begin
        instr_reg <= pwdata;
      end
      if (state_reg == ST_READ_S) begin
        d_reg <= mem_rdata;
      end
    end
  end

  // Arithmetic outcome held for the commit cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= RST_WORD;
      z_new_reg <= 1'b0;
      c_new_reg <= 1'b0;
      wr_pend_reg <= 1'b0;
      jump_pend_reg <= 1'b0;
      exec_pend_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      exec_pend_reg <= f_exec & alu_bus.legal;
      result_reg <= alu_bus.result;
      z_new_reg <= alu_bus.z_out;
      c_new_reg <= alu_bus.c_out;
      wr_pend_reg <= f_exec & alu_bus.legal & alu_bus.write;
      jump_pend_reg <= f_exec & alu_bus.legal & alu_bus.jump;
    end
  end

  // Flags: set by software or by a committed instruction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      z_reg <= 1'b0;
      c_reg <= 1'b0;
    end else if (commit & exec_pend_reg) begin
      z_reg <= z_new_reg;
      c_reg <= c_new_reg;
    end else if (wr_ok & hit_flags) begin
      z_reg <= pwdata[FLAG_Z_BIT];
      c_reg <= pwdata[FLAG_C_BIT];
    end
  end

  // Program counter: step or jump to the source address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_reg <= RST_PC;
    end else if (commit) begin
      pc_reg <= jump_pend_reg ? f_src : pc_reg + 9'h001;
    end else if (wr_ok & hit_pc) begin
      pc_reg <= pwdata[8:0];
    end
  end

  // Memory pointer and completion status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr_reg <= RST_PC;
      wrote_reg <= 1'b0;
      jumped_reg <= 1'b0;
      illegal_reg <= 1'b0;
    end else begin
      if (wr_ok & hit_maddr) begin
        mem_addr_reg <= pwdata[8:0];
      end
      if (commit) begin
        wrote_reg <= wr_pend_reg;
        jumped_reg <= jump_pend_reg;
        illegal_reg <= ~alu_bus.legal;
      end
    end
  end

endmodule : cea_core

// ### rtl/cea_pkg.sv
/*
 * Shared constants for the extended arithmetic and compare datapath:
 * opcodes, instruction field positions, register offsets, reset values,
 * cycle counts and the sequencer state type.
 * Assumes a 32-bit APB register bus and a single pclk domain.
 */
package cea_pkg;

  // ****************************************************************
  // Clock and cycle counts
  // ****************************************************************
  localparam int CLK_MHZ = 25;
  localparam int INSTR_CLOCKS = 4;
  localparam int NOJUMP_CLOCKS = 8;
  localparam logic [3:0] EXTRA_WAIT =
    4'(NOJUMP_CLOCKS - INSTR_CLOCKS);

  // ****************************************************************
  // Instruction word layout
  // ****************************************************************
  localparam int OPC_LSB = 26;
  localparam int EFF_LSB = 22;
  localparam int COND_LSB = 18;
  localparam int DST_LSB = 9;
  localparam int SRC_LSB = 0;
  localparam int RESULT_BIT = 1;
  localparam int IMM_BIT = 0;
  localparam logic [3:0] COND_ALWAYS = 4'hf;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [5:0] OP_SIGNED_COMPARE = 6'h30;
  localparam logic [5:0] OP_SIGNED_COMPARE_CHAINED = 6'h31;
  localparam logic [5:0] OP_ADD_WITH_CARRY_CHAINED = 6'h32;
  localparam logic [5:0] OP_SUBTRACT_WITH_BORROW_CHAINED = 6'h33;
  localparam logic [5:0] OP_SIGNED_ADD = 6'h34;
  localparam logic [5:0] OP_SIGNED_SUBTRACT = 6'h35;
  localparam logic [5:0] OP_SIGNED_ADD_CHAINED = 6'h36;
  localparam logic [5:0] OP_SIGNED_SUBTRACT_CHAINED = 6'h37;
  localparam logic [5:0] OP_CONDITIONAL_SUBTRACT = 6'h38;
  localparam logic [5:0] OP_DECREMENT_BRANCH_NONZERO = 6'h39;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_MEM_ADDR = 8'h10;
  localparam logic [7:0] ADDR_MEM_DATA = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;

  localparam int ST_BUSY_BIT = 0;
  localparam int ST_WROTE_BIT = 1;
  localparam int ST_JUMP_BIT = 2;
  localparam int ST_ILLEGAL_BIT = 3;
  localparam int FLAG_Z_BIT = 0;
  localparam int FLAG_C_BIT = 1;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [8:0] RST_PC = 9'h000;
  localparam int MEM_WORDS = 512;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ_D = 3'b001,
    ST_READ_S = 3'b010,
    ST_EXEC = 3'b011,
    ST_COMMIT = 3'b100,
    ST_HOLD = 3'b101
  } cea_state_t;

endpackage : cea_pkg

// ### rtl/cea_regmem.sv
/*
 * Register memory of 512 words, one synchronous read port and one
 * write port. Assumes the caller never needs read-during-write data.
 */
`timescale 1ns/1ps
module cea_regmem
  import cea_pkg::*;
(
  input wire logic pclk,
  input wire logic [8:0] raddr,
  output logic [31:0] rdata,
  input wire logic we,
  input wire logic [8:0] waddr,
  input wire logic [31:0] wdata
);

  logic [31:0] mem [MEM_WORDS];

  // Write then registered read
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : cea_regmem

// ### testbench/cea_core_bench.sv
/* Self-checking bench for cea_core over APB.
   Assumes a 25 MHz pclk and the bound port checker. */
`timescale 1ns/1ps
module cea_core_bench
  import cea_pkg::*;
;
  typedef struct packed {
    logic [31:0] e;
    logic [31:0] m;
    logic er;
  } cea_note_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'h71cc1721;
  cea_note_t notes[$];
  cea_note_t note;

  cea_core uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free running clock
  initial begin
    forever #20 pclk = ~pclk;
  end

  // ****
  // Checking and closing
  // ****
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Oldest note against each completed access
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note.er});
      if (note.m != 32'h0)
        check("prdata", prdata & note.m, note.e & note.m);
    end
  end

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      conclude();
    end
  end

  // ****
  // Bus tasks
  // ****
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, e, m, input logic er);
    int n;
    notes.push_back('{e, m, er});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) n_errors++;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    xfer(1'b0, a, 32'($random(seed)), e, m, 1'b0);
  endtask : rd

  // Reference: {wrote, jump, z, c, result}
  function automatic logic [35:0] model(input logic [5:0] op,
      input logic rb, input logic [31:0] d, s, input logic zi, ci);
    logic sub, ext, cx, z, c, w, j;
    logic [33:0] sx, ux;
    logic [31:0] r;
    sub = op[0] || op == OP_SIGNED_COMPARE;
    ext = op inside {6'h31, 6'h32, 6'h33, 6'h36, 6'h37};
    cx = ext & ci;
    sx = sub ? {{2{d[31]}}, d} - {{2{s[31]}}, s} - 34'(cx)
             : {{2{d[31]}}, d} + {{2{s[31]}}, s} + 34'(cx);
    ux = sub ? {2'b0, d} - {2'b0, s} - 34'(cx)
             : {2'b0, d} + {2'b0, s} + 34'(cx);
    r = ux[31:0];
    z = r == 32'h0 && (zi || !ext);
    c = op < 6'h32 ? sx[33] : op < 6'h34 ? ux[32] : sx[32] ^ sx[31];
    w = rb && op > 6'h31;
    j = 1'b0;
    if (op == OP_CONDITIONAL_SUBTRACT) begin
      c = d >= s;
      z = d == s;
      r = c ? d - s : d;
      w = rb && c;
    end
    if (op == OP_DECREMENT_BRANCH_NONZERO) begin
      r = d - 32'h1;
      z = r == 32'h0;
      c = d == 32'h0;
      w = rb;
      j = !z;
    end
    return {w, j, z, c, r};
  endfunction : model

  // One instruction: load, execute, poll, read back
  task automatic run(input logic [5:0] op, input logic rb, imm,
      input logic [31:0] dv, sv, input logic zi, ci, input logic [8:0] dst);
    logic [35:0] x;
    logic [8:0] src;
    logic [8:0] pc0;
    logic tk;
    src = dst + 9'h5;
    x = model(op, rb, dv, imm ? {23'h0, src} : sv, zi, ci);
    pc0 = 9'($random(seed));
    tk = x[34];
    wr(ADDR_MEM_ADDR, {23'h0, dst});
    wr(ADDR_MEM_DATA, dv);
    if (!imm) begin
      wr(ADDR_MEM_ADDR, {23'h0, src});
      wr(ADDR_MEM_DATA, sv);
    end
    wr(ADDR_FLAGS, {30'h0, ci, zi});
    wr(ADDR_PC, {23'h0, pc0});
    wr(ADDR_INSTR, {op, 2'b00, rb, imm, COND_ALWAYS, dst, src});
    rd(ADDR_STATUS, 32'h1, 32'h1);
    xfer(1'b1, ADDR_FLAGS, 32'h3, 32'h0, 32'h0, 1'b1);
    if (op == OP_DECREMENT_BRANCH_NONZERO && !tk)
      repeat (2) rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_STATUS, {29'h0, tk, x[35], 1'b0}, 32'hf);
    rd(ADDR_FLAGS, {30'h0, x[32], x[33]}, 32'h3);
    rd(ADDR_PC, {23'h0, tk ? src : pc0 + 9'h1}, 32'h1ff);
    if (op != OP_CONDITIONAL_SUBTRACT || x[32])
      rd(ADDR_RESULT, x[31:0], '1);
    wr(ADDR_MEM_ADDR, {23'h0, dst});
    rd(ADDR_MEM_DATA, x[35] ? x[31:0] : dv, '1);
  endtask : run

  // ****
  // Main sequence
  // ****
  initial begin
    logic [7:0] regs [6];
    logic [31:0] d;
    logic [31:0] s;
    regs = '{ADDR_INSTR, ADDR_STATUS, ADDR_FLAGS, ADDR_PC, ADDR_MEM_ADDR,
      ADDR_RESULT};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (regs[i]) rd(regs[i], 32'h0, '1);
    xfer(1'b1, ADDR_STATUS, 32'hf, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, ADDR_RESULT, 32'h1, 32'h0, 32'h0, 1'b1);
    repeat (4) xfer(1'b0, 8'h1c | 8'($random(seed) & 32'he0), 32'h0,
      32'h0, 32'h0, 1'b1);
    d = $random(seed);
    wr(ADDR_FLAGS, d);
    rd(ADDR_FLAGS, d, 32'h3);
    wr(ADDR_PC, d);
    rd(ADDR_PC, d, 32'h1ff);
    rd(ADDR_STATUS, 32'h0, '1);
    $display("test registers done");
    // Unknown opcode, then a condition field that never executes
    wr(ADDR_INSTR, {6'h3f, 4'h2, COND_ALWAYS, 18'h0});
    repeat (2) rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_STATUS, 32'h8, 32'hf);
    wr(ADDR_INSTR, {OP_SIGNED_ADD, 4'h2, 4'h0, 18'h0});
    repeat (2) rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_STATUS, 32'h0, 32'hf);
    rd(ADDR_FLAGS, d, 32'h3);
    rd(ADDR_PC, {23'h0, 9'(d) + 9'h2}, 32'h1ff);
    $display("test decode done");
    for (int o = 6'h30; o <= 6'h39; o++) begin
      for (int t = 0; t < 4; t++) begin
        d = $random(seed);
        s = t == 1 ? d : $random(seed);
        if (t > 1) begin
          d = t == 2 ? (o == 6'h39 ? 32'h0 : 32'h7fffffff)
                     : (o == 6'h39 ? 32'h1 : 32'h80000000);
          s = (t == 3 && o == 6'h38) ? 32'hffffffff : 32'h1;
        end
        run(6'(o), !(o == 6'h33 && t % 2 == 1), t == 0, d, s,
          1'($random(seed)), 1'($random(seed)), 9'($random(seed)));
      end
      $display("test opcode %h done", o);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    conclude();
  end
endmodule : cea_core_bench

// ### testbench/cea_core_chk.sv
/* Concurrent checks on the APB ports of cea_core.
   Assumes one pclk domain and presetn active low. */
`timescale 1ns/1ps
module cea_core_chk
  import cea_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ****
  // Decodes
  // ****
  wire acc;
  wire setup;
  wire instr_ok;
  wire st_setup;
  wire unmapped;
  wire flag_wr;
  logic [31:0] wdat_reg;
  // Phases of the transfer
  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign instr_ok = acc && pwrite && paddr == ADDR_INSTR && !pslverr;
  assign st_setup = setup && !pwrite && paddr == ADDR_STATUS;
  assign unmapped = paddr > ADDR_RESULT || paddr[1:0] != 2'b00;
  assign flag_wr = acc && pwrite && paddr == ADDR_FLAGS && !pslverr;
  // Last write data seen in an access
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) wdat_reg <= 32'h0;
    else if (acc && pwrite) wdat_reg <= pwdata;
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_in_access: assert property (pslverr |-> acc)
    else $error("pslverr outside access");
  a_unmapped_err: assert property (acc && unmapped |-> pslverr)
    else $error("unmapped access not refused");
  a_readonly_err: assert property (acc && pwrite &&
    (paddr == ADDR_STATUS || paddr == ADDR_RESULT) |-> pslverr)
    else $error("read-only write not refused");
  a_busy_refuse: assert property (instr_ok ##[1:4] flag_wr |-> 1'b0)
    else $error("flags written while busy");
  a_busy_seen: assert property (instr_ok ##[1:4] st_setup
    |=> prdata[ST_BUSY_BIT])
    else $error("busy missing during execution");
  a_nojump_done: assert property (instr_ok ##1 (!instr_ok)[*8]
    ##1 st_setup |=> !prdata[ST_BUSY_BIT])
    else $error("busy still set after eight clocks");
  a_prdata_hold: assert property (!setup |=> $stable(prdata))
    else $error("prdata changed without setup");
  a_flags_back: assert property (flag_wr ##1
    (setup && !pwrite && paddr == ADDR_FLAGS)
    |=> prdata[1:0] == wdat_reg[1:0])
    else $error("flags readback differs");
  c_instr: cover property (instr_ok);
  c_unmapped: cover property (acc && unmapped && pslverr);
  c_refuse: cover property (instr_ok ##[1:4] (acc && pwrite && pslverr));
  c_nojump: cover property (instr_ok ##1 (!instr_ok)[*8] ##1 st_setup);
endmodule : cea_core_chk

bind cea_core cea_core_chk chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
